// *** aof_pkg.sv ***
// Register map, field layout and pattern constants of the output format configuration bank.
package aof_pkg;
   // ---------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ---------------------------------------------------------------
   localparam logic [5:0] IDX_TEST_FMT = 6'h00;
   localparam logic [5:0] IDX_CLK_GAIN = 6'h04;
   localparam logic [5:0] IDX_CUST_LO = 6'h0b;
   localparam logic [5:0] IDX_FINE_CUST = 6'h0c;
   localparam logic [5:0] IDX_OUT_CFG = 6'h0d;
   localparam logic [5:0] IDX_STATUS = 6'h0e;
   localparam int REG_W = 11;
   localparam logic [10:0] RST_VAL = 11'h000;
   // ---------------------------------------------------------------
   // Writable bits of each register.
   // ---------------------------------------------------------------
   localparam logic [10:0] MASK_TEST_FMT = 11'h2e0;
   localparam logic [10:0] MASK_CLK_GAIN = 11'h07c;
   localparam logic [10:0] MASK_CUST_LO = 11'h7ff;
   localparam logic [10:0] MASK_FINE_CUST = 11'h707;
   localparam logic [10:0] MASK_OUT_CFG = 11'h4f7;
   // ---------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------
   localparam int POS_FORMAT = 9;
   localparam int POS_PAT_LO = 5;
   localparam int POS_CLKG_LO = 2;
   localparam int POS_FINE_LO = 8;
   localparam int POS_OVRD = 10;
   localparam int CUST_HI_W = 3;
   // Effective interface vector, bit order shared by pins and register.
   localparam int IF_TWO = 0;
   localparam int IF_SDR = 1;
   localparam int IF_X16 = 2;
   localparam int IF_RISE = 3;
   localparam int IF_COARSE = 4;
   localparam int IF_LSB = 5;
   localparam int IF_BITW = 6;
   // ---------------------------------------------------------------
   // Test pattern codes and words.
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PAT_NORMAL = 3'h0,
      PAT_ZEROS = 3'h1,
      PAT_ONES = 3'h2,
      PAT_TOGGLE = 3'h3,
      PAT_UNUSED = 3'h4,
      PAT_CUSTOM = 3'h5,
      PAT_DESKEW = 3'h6,
      PAT_SYNC = 3'h7
   } aof_pat_e;
   localparam logic [13:0] WORD_ONES = 14'h3fff;
   localparam logic [13:0] WORD_TOG_A = 14'h2aaa;
   localparam logic [13:0] WORD_TOG_B = 14'h1555;
   localparam logic [13:0] WORD_SYNC = 14'h3f80;
   localparam logic [4:0] LEN_1W_14 = 5'h0e;
   localparam logic [4:0] LEN_1W_16 = 5'h10;
   localparam logic [4:0] LEN_2W_14 = 5'h07;
   localparam logic [4:0] LEN_2W_16 = 5'h08;
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } aof_bus_e;
endpackage : aof_pkg

// *** aof_rx_model.sv ***
// Receiver model that captures the serial lanes and rebuilds channel A words.
`timescale 1ns/1ps
module aof_rx_model
(
   input wire logic clk_link,
   input wire logic reset,
   input wire logic lane_a,
   input wire logic lane_b,
   input wire logic frame_clk,
   input wire logic capture_rising,
   input wire logic two_wire,
   input wire logic bit_wise,
   input wire logic lsb_first,
   input wire logic x16,
   output logic [13:0] word,
   output int frames
);
   logic [15:0] stream = 16'h0000;
   logic fc_q = 1'b0;
   int k = 0;
   int h;
   initial
   begin
      word = 14'h0000;
      frames = 0;
   end
   // Both edges of one bit period see the same bit, so sampling on the chosen edge is safe.
   always @(clk_link)
   begin
      if (reset)
      begin
         frames = 0;
         k = 0;
      end
      else if (clk_link === capture_rising)
      begin
         if (frame_clk && !fc_q)
         begin
            for (int i = 0; i < 14; i++)
               word[i] = lsb_first ? stream[i] : stream[13 - i];
            frames = frames + 1;
            k = 0;
         end
         h = x16 ? 8 : 7;
         if (!two_wire && k < 16)
            stream[k] = lane_a;
         else if (bit_wise && k < 8)
         begin
            stream[2 * k] = lane_a;
            stream[2 * k + 1] = lane_b;
         end
         else if (k < h)
         begin
            stream[k] = lane_a;
            stream[h + k] = lane_b;
         end
         k = k + 1;
         fc_q = frame_clk;
      end
   end
endmodule : aof_rx_model

// *** aof_top.sv ***
// Output format configuration bank with its link-side serial word formatter.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module aof_top
   import aof_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pin_two_wire,
   input wire logic pin_sdr,
   input wire logic pin_x16,
   input wire logic pin_rising,
   input wire logic pin_coarse,
   input wire logic pin_lsb_first,
   input wire logic pin_bit_wise,
   output logic [4:0] clk_buf_gain,
   output logic [2:0] fine_gain,
   output logic coarse_gain_en,
   input wire logic clk_link,
   input wire logic [13:0] sample_a,
   input wire logic [13:0] sample_b,
   input wire logic [13:0] sample_c,
   input wire logic [13:0] sample_d,
   output logic [3:0] lane_first,
   output logic [3:0] lane_second,
   output logic frame_clk,
   output logic bit_clk_sdr,
   output logic capture_rising
);
   // ---------------------------------------------------------------
   // Functions.
   // ---------------------------------------------------------------
   function automatic logic [13:0] build_word(input logic [13:0] smp, input logic [2:0] pat,
                                              input logic straight, input logic [13:0] cust,
                                              input logic tog);
      logic [13:0] w;
      w = '0;
      case (pat)
         PAT_NORMAL: w = straight ? smp : {~smp[13], smp[12:0]};
         PAT_ONES: w = WORD_ONES;
         PAT_TOGGLE: w = tog ? WORD_TOG_B : WORD_TOG_A;
         PAT_CUSTOM: w = cust;
         PAT_SYNC: w = WORD_SYNC;
         default: w = '0;
      endcase
      return w;
   endfunction : build_word

   function automatic logic [15:0] order_word(input logic [13:0] w, input logic lsb);
      logic [15:0] s;
      s = '0;
      for (int k = 0; k < 14; k++)
      begin
         s[k] = lsb ? w[k] : w[13 - k];
      end
      return s;
   endfunction : order_word

   function automatic logic lane_bit(input logic [15:0] s, input logic [4:0] idx,
                                     input logic two, input logic bitw, input logic x16,
                                     input logic sel);
      logic [4:0] pos;
      pos = idx;
      if (two && bitw)
      begin
         pos = 5'((idx << 1) + {4'h0, sel});
      end
      else if (two && sel)
      begin
         pos = 5'(idx + (x16 ? LEN_2W_16 : LEN_2W_14));
      end
      return s[pos[3:0]];
   endfunction : lane_bit

   // ---------------------------------------------------------------
   // Register bus slave.
   // ---------------------------------------------------------------
   aof_bus_e bus_state;
   logic [10:0] reg_test_fmt;
   logic [10:0] reg_cust_lo;
   logic [10:0] reg_fine_cust;
   logic [10:0] reg_out_cfg;
   logic [6:0] eff_if;
   logic xfer_busy;
   wire [5:0] acc_idx = avs_address[7:2];
   wire acc_req = avs_read | avs_write;
   wire acc_done = (bus_state == BUS_ANSWER);
   wire wr_go = acc_done & avs_write;
   wire hit_test_fmt = (acc_idx == IDX_TEST_FMT);
   wire hit_clk_gain = (acc_idx == IDX_CLK_GAIN);
   wire hit_cust_lo = (acc_idx == IDX_CUST_LO);
   wire hit_fine_cust = (acc_idx == IDX_FINE_CUST);
   wire hit_out_cfg = (acc_idx == IDX_OUT_CFG);
   wire hit_status = (acc_idx == IDX_STATUS);
   wire [10:0] wr_val = avs_writedata[10:0];
   wire [10:0] clk_gain_view = {4'h0, clk_buf_gain, 2'h0};
   wire [10:0] status_view = {3'h0, xfer_busy, eff_if};
   wire [10:0] rd_val = hit_test_fmt ? reg_test_fmt :
                        hit_clk_gain ? clk_gain_view :
                        hit_cust_lo ? reg_cust_lo :
                        hit_fine_cust ? reg_fine_cust :
                        hit_out_cfg ? reg_out_cfg :
                        hit_status ? status_view : RST_VAL;
   wire [10:0] gain_w = wr_val & MASK_CLK_GAIN;
   wire aof_bus_e next_bus = (bus_state == BUS_IDLE && acc_req) ? BUS_ANSWER : BUS_IDLE;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         bus_state <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end
      else if (clk_en)
      begin
         bus_state <= next_bus;
         avs_waitrequest <= (next_bus != BUS_ANSWER);
         avs_readdata <= {21'h0, rd_val};
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         reg_test_fmt <= RST_VAL;
         reg_cust_lo <= RST_VAL;
         reg_fine_cust <= RST_VAL;
         reg_out_cfg <= RST_VAL;
         clk_buf_gain <= RST_VAL[4:0];
      end
      else if (clk_en && wr_go)
      begin
         if (hit_test_fmt)
            reg_test_fmt <= wr_val & MASK_TEST_FMT;
         if (hit_clk_gain)
            clk_buf_gain <= gain_w[POS_CLKG_LO +: 5];
         if (hit_cust_lo)
            reg_cust_lo <= wr_val & MASK_CUST_LO;
         if (hit_fine_cust)
            reg_fine_cust <= wr_val & MASK_FINE_CUST;
         if (hit_out_cfg)
            reg_out_cfg <= wr_val & MASK_OUT_CFG;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchroniser and effective interface settings.
   // ---------------------------------------------------------------
   logic [6:0] pin_s1;
   logic [6:0] pin_s2;
   wire [6:0] pin_raw = {pin_bit_wise, pin_lsb_first, pin_coarse, pin_rising, pin_x16,
                         pin_sdr, pin_two_wire};
   wire [6:0] reg_if = {reg_out_cfg[7:4], reg_out_cfg[2:0]};
   wire ovrd = reg_out_cfg[POS_OVRD];
   wire [6:0] next_eff_if = ovrd ? reg_if : pin_s2;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         eff_if <= '0;
         fine_gain <= '0;
         coarse_gain_en <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         eff_if <= next_eff_if;
         fine_gain <= reg_fine_cust[POS_FINE_LO +: 3];
         coarse_gain_en <= eff_if[IF_COARSE];
      end
   end

   // ---------------------------------------------------------------
   // Settings crossing to the link clock by a toggle handshake.
   // ---------------------------------------------------------------
   // The hold word stays still while a toggle is in flight, so the link
   // side always samples a settled word even though it is multi-bit.
   logic [24:0] xfer_hold;
   logic xfer_req;
   logic ack_s1;
   logic ack_s2;
   logic link_ack;
   wire [13:0] cust_word = {reg_fine_cust[CUST_HI_W - 1:0], reg_cust_lo};
   wire [24:0] xfer_word = {eff_if, reg_test_fmt[POS_FORMAT],
                            reg_test_fmt[POS_PAT_LO +: 3], cust_word};
   assign xfer_busy = xfer_req ^ ack_s2;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         xfer_hold <= '0;
         xfer_req <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end
      else if (clk_en)
      begin
         ack_s1 <= link_ack;
         ack_s2 <= ack_s1;
         if (!xfer_busy && xfer_word != xfer_hold)
         begin
            xfer_hold <= xfer_word;
            xfer_req <= ~xfer_req;
         end
      end
   end

   // ---------------------------------------------------------------
   // Link clock domain.
   // ---------------------------------------------------------------
   logic rst_l1;
   logic rst_l2;
   logic ce_l1;
   logic ce_l2;
   logic req_s1;
   logic req_s2;
   logic req_s3;
   logic [24:0] l_cfg;

   always_ff @(posedge clk_link)
   begin
      rst_l1 <= reset;
      rst_l2 <= rst_l1;
      ce_l1 <= clk_en;
      ce_l2 <= ce_l1;
   end

   always_ff @(posedge clk_link)
   begin
      if (rst_l2)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         link_ack <= 1'b0;
         l_cfg <= '0;
      end
      else if (ce_l2)
      begin
         req_s1 <= xfer_req;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         link_ack <= req_s2;
         if (req_s2 != req_s3)
            l_cfg <= xfer_hold;
      end
   end

   wire [13:0] l_cust = l_cfg[13:0];
   wire [2:0] l_pat = l_cfg[16:14];
   wire l_straight = l_cfg[17];
   wire [6:0] l_if = l_cfg[24:18];

   // ---------------------------------------------------------------
   // Frame serializer.
   // ---------------------------------------------------------------
   // Each rising link clock edge moves one bit per lane; the line driver turns
   // this into the DDR or SDR bit clock that the mode outputs ask for.
   logic [4:0] bit_cnt;
   logic f_two;
   logic f_bitw;
   logic f_x16;
   logic f_dsk;
   logic dsk_ph;
   logic tog_ph;
   logic [15:0] strm [4];
   wire [4:0] f_len = f_two ? (f_x16 ? LEN_2W_16 : LEN_2W_14) :
                              (f_x16 ? LEN_1W_16 : LEN_1W_14);
   wire wrap = (bit_cnt >= f_len - 5'h01);
   wire next_two = wrap ? l_if[IF_TWO] : f_two;
   wire next_bitw = wrap ? l_if[IF_BITW] : f_bitw;
   wire next_x16 = wrap ? l_if[IF_X16] : f_x16;
   wire next_dsk = wrap ? (l_pat == PAT_DESKEW) : f_dsk;
   wire [4:0] next_cnt = wrap ? 5'h00 : 5'(bit_cnt + 5'h01);
   wire [4:0] half_len = next_x16 ? LEN_2W_16 : LEN_2W_14;
   wire [13:0] smp_arr [4];
   logic [15:0] next_strm [4];
   logic [3:0] next_first;
   logic [3:0] next_second;
   assign smp_arr[0] = sample_a;
   assign smp_arr[1] = sample_b;
   assign smp_arr[2] = sample_c;
   assign smp_arr[3] = sample_d;

   always_comb
   begin
      for (int c = 0; c < 4; c++)
      begin
         next_strm[c] = wrap ? order_word(build_word(smp_arr[c], l_pat, l_straight, l_cust,
                                                     tog_ph), l_if[IF_LSB]) : strm[c];
         next_first[c] = next_dsk ? ~dsk_ph :
                         lane_bit(next_strm[c], next_cnt, next_two, next_bitw, next_x16, 1'b0);
         next_second[c] = next_dsk ? ~dsk_ph :
                          (next_two & lane_bit(next_strm[c], next_cnt, next_two, next_bitw,
                                               next_x16, 1'b1));
      end
   end

   always_ff @(posedge clk_link)
   begin
      if (rst_l2)
      begin
         bit_cnt <= 5'h1f;
         {f_two, f_bitw, f_x16, f_dsk, dsk_ph, tog_ph} <= '0;
         strm <= '{default: '0};
         lane_first <= '0;
         lane_second <= '0;
         frame_clk <= 1'b0;
         bit_clk_sdr <= 1'b0;
         capture_rising <= 1'b0;
      end
      else if (ce_l2)
      begin
         bit_cnt <= next_cnt;
         {f_two, f_bitw, f_x16, f_dsk} <= {next_two, next_bitw, next_x16, next_dsk};
         dsk_ph <= ~dsk_ph;
         if (wrap)
            tog_ph <= ~tog_ph;
         strm <= next_strm;
         lane_first <= next_first;
         lane_second <= next_second;
         frame_clk <= (next_cnt < {1'b0, half_len[4:1]}) | (!next_two && next_cnt < half_len);
         bit_clk_sdr <= next_two & l_if[IF_SDR];
         capture_rising <= next_two & l_if[IF_SDR] & l_if[IF_RISE];
      end
   end

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   chk_gain_reset: assert property (@(posedge clk_sys) reset |=> clk_buf_gain == 5'h00)
      else $error("clock buffer gain not cleared by reset");
   chk_cust_low: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && wr_go && hit_cust_lo) |=> cust_word[10:0] == $past(avs_writedata[10:0]))
      else $error("custom low bits not taken from write");
   chk_cust_high: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && wr_go && hit_fine_cust) |=> cust_word[13:11] == $past(avs_writedata[2:0]))
      else $error("custom high bits not taken from write");
   chk_fine_gain: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && wr_go && hit_fine_cust) ##1 clk_en |=> fine_gain == $past(reg_fine_cust[10:8], 1))
      else $error("fine gain output not following register");
   chk_override_sel: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en |=> eff_if == ($past(ovrd) ? $past(reg_if) : $past(pin_s2)))
      else $error("override selects the wrong source");
   chk_coarse_out: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en |=> coarse_gain_en == $past(eff_if[IF_COARSE]))
      else $error("coarse gain not following effective setting");
   chk_zero_frame: assert property (@(posedge clk_link) disable iff (rst_l2)
      (ce_l2 && wrap && l_pat == PAT_ZEROS) |=> strm[0] == 16'h0000)
      else $error("zero pattern frame not all zeros");
   chk_deskew_flip: assert property (@(posedge clk_link) disable iff (rst_l2)
      (ce_l2 && f_dsk && $past(f_dsk) && $past(ce_l2)) |-> lane_first != $past(lane_first))
      else $error("deskew lanes did not alternate");
   chk_twowire_len: assert property (@(posedge clk_link) disable iff (rst_l2)
      (ce_l2 && wrap && l_if[IF_TWO] && l_if[IF_X16]) ##1 ce_l2[*8] |-> wrap)
      else $error("two-wire 16x frame is not eight bits long");
   chk_msb_order: assert property (@(posedge clk_link) disable iff (rst_l2)
      (ce_l2 && wrap && l_pat == PAT_CUSTOM && !l_if[IF_LSB])
      |=> strm[0][0] == $past(l_cust[13]))
      else $error("first serial bit is not the word MSB");
   chk_format_flip: assert property (@(posedge clk_link) disable iff (rst_l2)
      (ce_l2 && wrap && l_pat == PAT_NORMAL && !l_straight && !l_if[IF_LSB])
      |=> strm[0][0] == ~$past(sample_a[13]))
      else $error("two's complement MSB not inverted");
   cov_deskew: cover property (@(posedge clk_link) f_dsk && ce_l2);
   cov_bitwise: cover property (@(posedge clk_link) wrap && f_two && f_bitw);
   cov_override: cover property (@(posedge clk_sys) ovrd && clk_en);
   cov_xfer: cover property (@(posedge clk_sys) $rose(xfer_busy));
endmodule : aof_top

// *** tb_adc_output_format_config.sv ***
// Self-checking testbench of the output format configuration bank.
`timescale 1ns/1ps
module tb_adc_output_format_config
   import aof_pkg::*;
;
   logic clk_sys = 1'b0;
   logic clk_link = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [6:0] pins = 7'h00;
   logic [13:0] sa = 14'h0000;
   logic [13:0] sb = 14'h0000;
   logic [4:0] clk_buf_gain;
   logic [2:0] fine_gain;
   logic coarse_gain_en, frame_clk, bit_clk_sdr, capture_rising;
   logic [3:0] lane_first, lane_second;
   logic [10:0] cf = 11'h000;
   logic [13:0] rx_word;
   int rx_frames;
   int miscompares = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'hfc51;
   logic [31:0] rd, r;
   logic [13:0] cust;
   logic [6:0] eff;
   logic [2:0] p;
   logic fmt;
   logic [10:0] masks [5] = '{11'h2e0, 11'h07c, 11'h7ff, 11'h707, 11'h4f7};
   logic [7:0] addrs [6] = '{8'h00, 8'h10, 8'h2c, 8'h30, 8'h34, 8'h38};
   logic [4:0] gains [6] = '{5'h18, 5'h00, 5'h0c, 5'h0a, 5'h09, 5'h08};
   logic [10:0] cfgs [7] = '{11'h440, 11'h401, 11'h481, 11'h404, 11'h4c5, 11'h413, 11'h4b7};
   initial forever #20 clk_sys = ~clk_sys;
   initial
   begin
      #7;
      forever #80 clk_link = ~clk_link;
   end
   aof_top uut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_two_wire(pins[0]),
      .pin_sdr(pins[1]), .pin_x16(pins[2]), .pin_rising(pins[3]), .pin_coarse(pins[4]),
      .pin_lsb_first(pins[5]), .pin_bit_wise(pins[6]), .clk_buf_gain(clk_buf_gain),
      .fine_gain(fine_gain), .coarse_gain_en(coarse_gain_en), .clk_link(clk_link),
      .sample_a(sa), .sample_b(sb), .sample_c(sb), .sample_d(sa), .lane_first(lane_first),
      .lane_second(lane_second), .frame_clk(frame_clk), .bit_clk_sdr(bit_clk_sdr),
      .capture_rising(capture_rising));
   aof_rx_model rx (.clk_link(clk_link), .reset(reset), .lane_a(lane_first[0]),
      .lane_b(lane_second[0]), .frame_clk(frame_clk), .capture_rising(capture_rising),
      .two_wire(cf[0]), .bit_wise(cf[7]), .lsb_first(cf[6]), .x16(cf[2]), .word(rx_word),
      .frames(rx_frames));
   // ---------------------------------------------------------------
   // Helpers.
   // ---------------------------------------------------------------
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function logic [13:0] exp_word(input logic [2:0] pt, input logic f, input logic [13:0] s,
      input logic [13:0] w);
      case (pt)
         3'h0: return f ? s : {~s[13], s[12:0]};
         3'h2: return 14'h3fff;
         3'h3, 3'h6: return (w === 14'h1555) ? 14'h1555 : 14'h2aaa;
         3'h5: return cust;
         3'h7: return WORD_SYNC;
         default: return 14'h0000;
      endcase
   endfunction : exp_word
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
         miscompares++;
      end
   endtask : check
   // The request is raised one edge after the last release, so no signal changes twice.
   task bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= we;
      avs_read <= !we;
      avs_writedata <= wd;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50)
         miscompares++;
   endtask : bus
   task frames_wait(input int nf);
      int f0;
      int n;
      f0 = rx_frames;
      n = 0;
      while (rx_frames < f0 + nf && n < 3000)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 3000)
         miscompares++;
   endtask : frames_wait
   task final_report();
      if (miscompares == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   initial
   begin
      #1_000_000;
      miscompares++;
      final_report();
   end
   // ---------------------------------------------------------------
   // Main sequence; the link side copies reset through two link flops.
   // ---------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (addrs[i])
      begin
         bus(1'b0, addrs[i], 0);
         check("reset value", rd, 0);
      end
      for (int i = 0; i < 10; i++)
      begin
         r = xs();
         bus(1'b1, addrs[i % 5], r[10:0] & masks[i % 5]);
         bus(1'b0, addrs[i % 5], 0);
         check("readback", rd, r[10:0] & masks[i % 5]);
      end
      bus(1'b1, 8'h3c, xs());
      bus(1'b0, 8'h3c, 0);
      check("unmapped", rd, 0);
      foreach (gains[i])
      begin
         bus(1'b1, 8'h10, {gains[i], 2'b00});
         @(posedge clk_sys);
         check("clk_buf_gain", clk_buf_gain, gains[i]);
      end
      // A write held across a frozen stretch must wait until the enable returns.
      fork
         bus(1'b1, 8'h10, {5'h18, 2'b00});
         begin
            clk_en <= 1'b0;
            repeat (5) @(posedge clk_sys);
            check("frozen gain", clk_buf_gain, 5'h08);
            clk_en <= 1'b1;
         end
      join
      @(posedge clk_sys);
      check("thawed gain", clk_buf_gain, 5'h18);
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b1, 8'h30, i << 8);
         repeat (2) @(posedge clk_sys);
         check("fine_gain", fine_gain, i);
      end
      for (int i = 0; i < 8; i++)
      begin
         r = xs();
         pins <= r[6:0];
         cf <= r[17:7] & MASK_OUT_CFG;
         bus(1'b1, 8'h34, r[17:7] & MASK_OUT_CFG);
         repeat (4) @(posedge clk_sys);
         bus(1'b0, 8'h38, 0);
         eff = cf[10] ? {cf[7:4], cf[2:0]} : pins;
         check("effective", rd[6:0], eff);
         check("coarse_gain_en", coarse_gain_en, eff[4]);
         frames_wait(3);
         check("bit_clk_sdr", bit_clk_sdr, eff[0] & eff[1]);
         check("capture_rising", capture_rising, eff[0] & eff[1] & eff[3]);
      end
      r = xs();
      cust = r[13:0];
      bus(1'b1, 8'h2c, cust[10:0]);
      bus(1'b1, 8'h30, cust[13:11]);
      for (int i = 0; i < 16; i++)
      begin
         p = (i < 9) ? i[2:0] : 3'h5;
         fmt = (i == 8);
         r = xs();
         sa <= r[13:0];
         sb <= r[27:14];
         cf <= (i < 9) ? 11'h400 : cfgs[i - 9];
         bus(1'b1, 8'h34, (i < 9) ? 11'h400 : cfgs[i - 9]);
         bus(1'b1, 8'h00, {1'b0, fmt, 1'b0, p, 5'h00});
         frames_wait(6);
         check("rx word", rx_word, exp_word(p, fmt, sa, rx_word));
      end
      final_report();
   end
endmodule : tb_adc_output_format_config
